/* File: common/jog_pulse_pkg.sv */
// Constants for the jog-driven pulse-train positioning output block.
// Assumes a 100 MHz system clock and Avalon-MM register access.
package jog_pulse_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_HALF_NS = 50;
    localparam int PULSE_HALF_CYC =
        (PULSE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] HALF_RST = 16'(PULSE_HALF_CYC);

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_POS_LOW = 4'h8;
    localparam logic [3:0] OFS_POS_HIGH = 4'hC;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
    localparam logic [4:0] OFS_HALF = 5'h18;

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int CTRL_SEP_MODE_BIT = 0;
    localparam int CTRL_ADAPTER_BIT = 1;
    localparam int CTRL_DIR_INV_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // ----------------------------------------
    // Interrupt status fields
    // ----------------------------------------
    localparam int IRQ_ABEND_BIT = 0;
    localparam int IRQ_STOP_BIT = 1;
    localparam int IRQ_W = 2;

    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_FWD,
        RUN_REV
    } run_state_t;

endpackage

/* File: hdl/jog_pulse_out.sv */
// Jog-driven pulse-train output with travel limits and position count.
// Assumes switch inputs already synchronous to clk; Avalon-MM slave.
//
// Contract
// - Both limit inputs are normally closed: low means limit reached.
// - Both jog inputs are normally open: high means switch closed.
// - Forward runs while forward jog, both limits high, reverse jog low.
// - Pulse-plus-direction forward: pulse toggles, direction held high, main and adapter.
// - Separate-pulse forward: forward line toggles, reverse line held low.
// - Position count rises while forward pulses are emitted.
// - Jog release stops pulses; direction keeps its level, pulse lines low.
// - After stopping, position count holds its last value.
// - Forward limit during forward run stops like jog release but also sets abnormal-end.
// - A stop by the limit of the run direction sets the abnormal-end flag; the opposite limit stops without it.
// - Output destination and rotation setting choose lines and levels.
// - Reverse run decrements count and holds direction low while pulsing.
// - Reverse limit during reverse run halts pulses and sets abnormal-end.
`timescale 1ns/1ns
module jog_pulse_out
    import jog_pulse_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Switches
    input wire logic fwd_travel_limit_in,
    input wire logic rev_travel_limit_in,
    input wire logic jog_forward_in,
    input wire logic jog_reverse_in,
    // Drive outputs
    output logic pulse_train_out,
    output logic direction_out,
    output logic adapter_pulse_out,
    output logic adapter_direction_out,
    output logic abnormal_end_flag,
    output logic irq,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    run_state_t state_reg, state_next;
    logic [15:0] half_cnt_reg, half_cnt_next;
    logic [15:0] half_reg, half_next;
    logic phase_reg, phase_next;
    logic signed [31:0] pos_reg, pos_next;
    logic [2:0] ctrl_reg, ctrl_next;
    logic abend_reg, abend_next;
    logic [IRQ_W-1:0] ist_reg, ist_next;
    logic [IRQ_W-1:0] imask_reg, imask_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic pls_reg, pls_next;
    logic dir_reg, dir_next;
    logic apls_reg, apls_next;
    logic adir_reg, adir_next;
    logic irq_reg, irq_next;

    logic fwd_ok, rev_ok, fwd_go, rev_go, limit_hit, any_stop, step;
    logic sep_mode, to_adapter, dir_inv, line_a, line_b;
    logic acc, wr, rd;

    // ----------------------------------------
    // Run decisions
    // ----------------------------------------
    always_comb begin
        fwd_ok = fwd_travel_limit_in;
        rev_ok = rev_travel_limit_in;
        fwd_go = jog_forward_in && !jog_reverse_in && fwd_ok && rev_ok;
        rev_go = jog_reverse_in && !jog_forward_in && fwd_ok && rev_ok;
        sep_mode = ctrl_reg[CTRL_SEP_MODE_BIT];
        to_adapter = ctrl_reg[CTRL_ADAPTER_BIT];
        dir_inv = ctrl_reg[CTRL_DIR_INV_BIT];
        acc = (avs_read || avs_write) && !ack_reg;
        // Write lands at the edge that ends the transfer, one edge after the wait state ends
        wr = avs_write && ack_reg;
        rd = avs_read && !ack_reg;
    end

    // ----------------------------------------
    // Run state, pulse phase, position
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        half_cnt_next = half_cnt_reg;
        phase_next = phase_reg;
        pos_next = pos_reg;
        limit_hit = 1'b0;
        any_stop = 1'b0;
        step = 1'b0;
        unique case (state_reg)
            RUN_IDLE: begin
                phase_next = 1'b0;
                half_cnt_next = 16'h0000;
                if (fwd_go) begin
                    state_next = RUN_FWD;
                end else if (rev_go) begin
                    state_next = RUN_REV;
                end
            end
            RUN_FWD, RUN_REV: begin
                if (state_reg == RUN_FWD) begin
                    limit_hit = !fwd_ok;
                    any_stop = !fwd_go;
                end else begin
                    limit_hit = !rev_ok;
                    any_stop = !rev_go;
                end
                if (any_stop) begin
                    state_next = RUN_IDLE;
                    phase_next = 1'b0;
                    half_cnt_next = 16'h0000;
                end else if (half_cnt_reg + 16'h0001 >= half_reg) begin
                    half_cnt_next = 16'h0000;
                    phase_next = !phase_reg;
                    step = phase_reg;
                end else begin
                    half_cnt_next = half_cnt_reg + 16'h0001;
                end
                if (step) begin
                    if (state_reg == RUN_FWD) begin
                        pos_next = pos_reg + 32'sd1;
                    end else begin
                        pos_next = pos_reg - 32'sd1;
                    end
                end
            end
            default: state_next = RUN_IDLE;
        endcase
    end

    // ----------------------------------------
    // Output line mapping
    // ----------------------------------------
    always_comb begin
        // Line A carries pulses or forward pulses; line B direction or reverse
        if (sep_mode) begin
            line_a = (state_next == RUN_FWD) && phase_next;
            line_b = (state_next == RUN_REV) && phase_next;
        end else begin
            line_a = (state_next != RUN_IDLE) && phase_next;
            if (state_next == RUN_FWD) begin
                line_b = !dir_inv;
            end else if (state_next == RUN_REV) begin
                line_b = dir_inv;
            end else begin
                line_b = dir_reg | adir_reg;
            end
        end
        pls_next = !to_adapter && line_a;
        dir_next = !to_adapter && line_b;
        apls_next = to_adapter && line_a;
        adir_next = to_adapter && line_b;
    end

    // ----------------------------------------
    // Registers, flag and interrupt
    // ----------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        half_next = half_reg;
        imask_next = imask_reg;
        abend_next = abend_reg;
        ist_next = ist_reg;
        ack_next = acc;
        rdata_next = 32'h0000_0000;
        if (wr) begin
            unique case (avs_address)
                {1'b0, OFS_CTRL}: begin
                    ctrl_next = avs_writedata[2:0];
                    abend_next = 1'b0;
                end
                OFS_IRQ_STAT: ist_next = ist_reg & ~avs_writedata[IRQ_W-1:0];
                OFS_IRQ_MASK: imask_next = avs_writedata[IRQ_W-1:0];
                OFS_HALF: begin
                    if (avs_writedata[15:0] != 16'h0000) begin
                        half_next = avs_writedata[15:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Hardware set wins over software clear
        if (any_stop && limit_hit) begin
            abend_next = 1'b1;
            ist_next[IRQ_ABEND_BIT] = 1'b1;
        end
        if (any_stop) begin
            ist_next[IRQ_STOP_BIT] = 1'b1;
        end
        if (rd) begin
            unique case (avs_address)
                {1'b0, OFS_CTRL}: rdata_next = {29'h0, ctrl_reg};
                {1'b0, OFS_STATUS}: rdata_next = {26'h0, jog_reverse_in, jog_forward_in,
                    rev_travel_limit_in, fwd_travel_limit_in, abend_reg,
                    state_reg != RUN_IDLE};
                {1'b0, OFS_POS_LOW}: rdata_next = {16'h0, pos_reg[15:0]};
                {1'b0, OFS_POS_HIGH}: rdata_next = {16'h0, pos_reg[31:16]};
                OFS_IRQ_STAT: rdata_next = {30'h0, ist_reg};
                OFS_IRQ_MASK: rdata_next = {30'h0, imask_reg};
                OFS_HALF: rdata_next = {16'h0, half_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        irq_next = |(ist_next & imask_next);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= RUN_IDLE;
            half_cnt_reg <= 16'h0000;
            half_reg <= HALF_RST;
            phase_reg <= 1'b0;
            pos_reg <= 32'sh0000_0000;
            ctrl_reg <= CTRL_RST;
            abend_reg <= 1'b0;
            ist_reg <= '0;
            imask_reg <= '0;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            pls_reg <= 1'b0;
            dir_reg <= 1'b0;
            apls_reg <= 1'b0;
            adir_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            half_cnt_reg <= half_cnt_next;
            half_reg <= half_next;
            phase_reg <= phase_next;
            pos_reg <= pos_next;
            ctrl_reg <= ctrl_next;
            abend_reg <= abend_next;
            ist_reg <= ist_next;
            imask_reg <= imask_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            pls_reg <= pls_next;
            dir_reg <= dir_next;
            apls_reg <= apls_next;
            adir_reg <= adir_next;
            irq_reg <= irq_next;
        end
    end

    always_comb begin
        pulse_train_out = pls_reg;
        direction_out = dir_reg;
        adapter_pulse_out = apls_reg;
        adapter_direction_out = adir_reg;
        abnormal_end_flag = abend_reg;
        irq = irq_reg;
        avs_readdata = rdata_reg;
        avs_waitrequest = !ack_reg;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence fwd_running;
        state_reg == RUN_FWD;
    endsequence

    AST_FWD_START: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == RUN_IDLE && jog_forward_in && !jog_reverse_in && fwd_travel_limit_in
         && rev_travel_limit_in) |=> fwd_running)
        else $error("forward run did not start");
    AST_LIMIT_STOP: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == RUN_FWD && !fwd_travel_limit_in) |=> state_reg == RUN_IDLE)
        else $error("forward limit did not stop run");
    AST_JOG_STOP: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == RUN_FWD && !jog_forward_in) |=> !pulse_train_out && !adapter_pulse_out)
        else $error("pulse not low after jog release");
    AST_DIR_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == RUN_FWD && !ctrl_reg[CTRL_SEP_MODE_BIT] && !dir_inv
         && !ctrl_reg[CTRL_ADAPTER_BIT] && jog_forward_in && !jog_reverse_in
         && fwd_travel_limit_in && rev_travel_limit_in) |=> direction_out)
        else $error("direction not high in forward run");
    AST_SEP_REV_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        (fwd_running and ##0 (ctrl_reg[CTRL_SEP_MODE_BIT] == 1'b1))
        |-> !direction_out && !adapter_direction_out)
        else $error("reverse line active in forward run");
    AST_POS_UP: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == RUN_FWD && step) |=> pos_reg == $past(pos_reg) + 32'sd1)
        else $error("position did not increase by one");
    AST_POS_DN: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == RUN_REV && step) |=> pos_reg == $past(pos_reg) - 32'sd1)
        else $error("position did not decrease by one");
    AST_POS_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == RUN_IDLE) |=> pos_reg == $past(pos_reg))
        else $error("position moved while idle");
    AST_ABEND: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == RUN_REV && !rev_travel_limit_in)
        |=> abnormal_end_flag && ist_reg[IRQ_ABEND_BIT])
        else $error("abnormal end not flagged on limit");
    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
        irq == |(ist_reg & imask_reg))
        else $error("interrupt level disagrees with status and mask");
    AST_BUS_ACK: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_write && avs_waitrequest) |=> !avs_waitrequest)
        else $error("write not acknowledged next cycle");

endmodule

/* File: tb/drive_model.sv */
// Drive unit and operator switch model for the jog pulse bench.
// Assumes the bench sets switch commands right after a rising clock edge.
`timescale 1ns/1ns
module drive_model (
    // System
    input wire logic clk,
    // Operator commands
    input wire logic press_fwd,
    input wire logic press_rev,
    input wire logic hit_flim,
    input wire logic hit_rlim,
    // Drive lines: main pulse, main dir, adapter pulse, adapter dir
    input wire logic [3:0] lines,
    // Switch contacts
    output logic fwd_travel_limit_in,
    output logic rev_travel_limit_in,
    output logic jog_forward_in,
    output logic jog_reverse_in,
    // Rising edges counted by the drive, per line
    output int edges [4]
);
    logic [3:0] prev_reg = 4'h0;
    int count_reg [4] = '{default: 0};

    assign edges = count_reg;

    // Limit contacts open when actuated
    assign fwd_travel_limit_in = !hit_flim;
    assign rev_travel_limit_in = !hit_rlim;
    // Jog contacts close when pressed
    assign jog_forward_in = press_fwd;
    assign jog_reverse_in = press_rev;

    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (lines[i] === 1'b1 && prev_reg[i] === 1'b0) begin
                count_reg[i] <= count_reg[i] + 1;
            end
        end
        prev_reg <= lines;
    end
endmodule

/* File: tb/jog_pulse_output_with_limits_test.sv */
// Self-checking bench for the jog pulse output block.
// Assumes a drive model on the lines and an Avalon-MM master in tasks.
`timescale 1ns/1ns
module jog_pulse_output_with_limits_test;
    import jog_pulse_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic press_fwd = 1'b0, press_rev = 1'b0, hit_flim = 1'b0, hit_rlim = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
    logic avs_waitrequest, abnormal_end_flag, irq;
    logic fl, rl, jf, jr;
    wire [3:0] lines;
    int edges [4];
    int fails = 0, samples_checked = 0, exp_pos = 0;

    always #5 clk = ~clk;

    jog_pulse_out uut (.clk(clk), .rst_n(rst_n), .fwd_travel_limit_in(fl),
        .rev_travel_limit_in(rl), .jog_forward_in(jf), .jog_reverse_in(jr),
        .pulse_train_out(lines[0]), .direction_out(lines[1]),
        .adapter_pulse_out(lines[2]), .adapter_direction_out(lines[3]),
        .abnormal_end_flag(abnormal_end_flag), .irq(irq), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    drive_model drive (.clk(clk), .press_fwd(press_fwd), .press_rev(press_rev),
        .hit_flim(hit_flim), .hit_rlim(hit_rlim), .lines(lines),
        .fwd_travel_limit_in(fl), .rev_travel_limit_in(rl), .jog_forward_in(jf),
        .jog_reverse_in(jr), .edges(edges));

    // ----------------------------------------
    // Checking and verdict
    // ----------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task print_verdict;
        if (fails == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task bus_wr(input logic [4:0] a, input logic [31:0] v);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task bus_rd(input logic [4:0] a, output logic [31:0] v);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task check_pos;
        logic [31:0] lo, hi;
        bus_rd({1'b0, OFS_POS_LOW}, lo);
        bus_rd({1'b0, OFS_POS_HIGH}, hi);
        check({hi[15:0], lo[15:0]}, exp_pos);
    endtask

    // Jog run of n pulses on line ln; stop by jog release or by limit
    task run(input bit fwd, input bit lim, input int ln, input int oth,
             input logic lvl, input int n);
        int start;
        start = edges[ln];
        press_fwd <= fwd;
        press_rev <= !fwd;
        while (edges[ln] < start + n) @(posedge clk);
        while (lines[ln] !== 1'b0) @(posedge clk);
        check(lines[oth], lvl);
        if (lim && fwd) hit_flim <= 1'b1;
        else if (lim) hit_rlim <= 1'b1;
        else begin
            press_fwd <= 1'b0;
            press_rev <= 1'b0;
        end
        repeat (3) @(posedge clk);
        press_fwd <= 1'b0;
        press_rev <= 1'b0;
        hit_flim <= 1'b0;
        hit_rlim <= 1'b0;
        check(edges[ln] - start, n);
        check(lines[ln], 1'b0);
        check(lines[oth], lvl);
        check(abnormal_end_flag, lim);
        exp_pos += fwd ? n : -n;
        repeat (20) @(posedge clk);
        check(edges[ln] - start, n);
        check_pos();
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({lines, abnormal_end_flag, irq}, 32'h0);
        bus_rd(OFS_HALF, d);
        check(d, {16'h0, HALF_RST});
        bus_rd(5'h1C, d);
        check(d, 32'h0);
        run(1, 0, 0, 1, 1'b1, 3);
        bus_wr({1'b0, OFS_CTRL}, 32'h1);
        run(1, 0, 0, 1, 1'b0, 2);
        bus_wr({1'b0, OFS_CTRL}, 32'h2);
        run(1, 0, 2, 3, 1'b1, 2);
        press_fwd <= 1'b1;
        press_rev <= 1'b1;
        repeat (20) @(posedge clk);
        check(lines, 4'h8);
        bus_wr({1'b0, OFS_CTRL}, 32'h0);
        run(0, 0, 0, 1, 1'b0, 3);
        bus_wr({1'b0, OFS_CTRL}, 32'h4);
        run(0, 0, 0, 1, 1'b1, 6);
        bus_wr({1'b0, OFS_CTRL}, 32'h0);
        run(1, 1, 0, 1, 1'b1, 2);
        bus_rd({1'b0, OFS_STATUS}, d);
        check(d, 32'h0000_000E);
        bus_rd(OFS_IRQ_STAT, d);
        check(d[1:0], 2'h3);
        check(irq, 1'b0);
        bus_wr(OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        bus_wr(OFS_IRQ_STAT, 32'h3);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        bus_wr({1'b0, OFS_CTRL}, 32'h1);
        repeat (2) @(posedge clk);
        check(abnormal_end_flag, 1'b0);
        run(0, 1, 1, 0, 1'b0, 2);
        check(irq, 1'b1);
        print_verdict();
    end

    // Watchdog well past the few hundred cycles the tests need
    initial begin
        #300000;
        fails++;
        print_verdict();
    end
endmodule
